// >>> hdl/encoder_pulse_output_divider_params.svh
// Constants for the encoder pulse output divider.
// Assumes inclusion by the package and the divider module.
`ifndef ENCODER_PULSE_OUTPUT_DIVIDER_PARAMS_SVH
`define ENCODER_PULSE_OUTPUT_DIVIDER_PARAMS_SVH

// ----------------------------------------
// Clock and output rate
// ----------------------------------------
`define CLK_SYS_HZ 100000000
`define PULSE_RATE_MAX_PPS 1600000
`define EDGES_PER_PULSE 4
// Least gap between output edges, rounded up
`define EDGE_GAP_CYC ((`CLK_SYS_HZ + `EDGES_PER_PULSE * `PULSE_RATE_MAX_PPS - 1) / (`EDGES_PER_PULSE * `PULSE_RATE_MAX_PPS))

// ----------------------------------------
// Pulses per revolution setting
// ----------------------------------------
`define PPR_DEFAULT 32'h0000_0800
`define PPR_MIN 32'h0000_0010
`define PPR_MAX_13BIT 32'h0000_0800
`define PPR_MAX_17BIT 32'h0000_4000
`define PPR_MAX_20BIT 32'h0004_0000
`define PPR_STEP1_TOP 32'h0000_4000
`define PPR_STEP2_TOP 32'h0000_8000
`define PPR_STEP4_TOP 32'h0001_0000
`define PPR_STEP8_TOP 32'h0002_0000

// ----------------------------------------
// Encoder counts per revolution
// ----------------------------------------
`define COUNTS_13BIT 21'h00_2000
`define COUNTS_17BIT 21'h02_0000
`define COUNTS_20BIT 21'h10_0000

// ----------------------------------------
// Speed limits in rev/min
// ----------------------------------------
`define SPEED_LIM_0 16'h1770
`define SPEED_LIM_1 16'h0BB8
`define SPEED_LIM_2 16'h05DC
`define SPEED_LIM_3 16'h02EE
`define SPEED_LIM_4 16'h0177

`endif

// >>> hdl/enc_pkg.sv
// Types for the encoder pulse output divider.
// Assumes the params header sits beside this file.
`include "encoder_pulse_output_divider_params.svh"

package enc_pkg;

    typedef enum logic [1:0] {
        RES_13BIT,
        RES_17BIT,
        RES_20BIT
    } enc_res_t;

    typedef struct packed {
        logic step;
        logic dir;
        logic index;
    } enc_in_t;

    typedef struct packed {
        logic setting_alarm;
        logic overspeed_alarm;
    } alarm_t;

endpackage : enc_pkg

// >>> hdl/encoder_pulse_output_divider.sv
// Divided quadrature output with origin pulse and alarms.
// Assumes encoder steps arrive synchronous to clk_sys, one per count at most.
//
// Contract
// - A and B quadrature, ninety degrees apart.
// - Each phase has an inverted companion output.
// - One origin pulse per motor revolution.
// - Origin pulse width equals phase A pulse.
// - Direction select keeps same phase form.
// - Divide counts to set pulses, min 16.
// - Setting limit depends on encoder resolution.
// - Setting granularity grows with its range.
// - Bad setting raises setting alarm.
// - Speed limit halves per setting range.
// - Speed above limit raises overspeed alarm.
// - Output rate capped near 1.6 Mpps.
`timescale 1ns/10ps
`include "encoder_pulse_output_divider_params.svh"

module encoder_pulse_output_divider #(
    parameter int SPEED_W = 16,
    parameter int GAP_CYC = `EDGE_GAP_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Sync reset, active high
    input wire enc_pkg::enc_in_t enc_in, // Encoder step, direction, index
    input wire enc_pkg::enc_res_t enc_res, // Encoder resolution
    input wire logic [31:0] pulses_per_rev_setting, // Output pulses per rev
    input wire logic rotation_direction_select, // Reverse rotation mode
    input wire logic [SPEED_W-1:0] motor_speed_rpm, // Speed magnitude
    output logic quad_out_a, // Phase A
    output logic quad_out_a_n, // Phase A inverted
    output logic quad_out_b, // Phase B
    output logic quad_out_b_n, // Phase B inverted
    output logic origin_pulse_out, // Phase C
    output logic origin_pulse_out_n, // Phase C inverted
    output enc_pkg::alarm_t alarms // Sticky alarms
);
    import enc_pkg::*;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic [20:0] res_counts(input enc_res_t r);
        if (r == RES_13BIT) begin
            return `COUNTS_13BIT;
        end else if (r == RES_17BIT) begin
            return `COUNTS_17BIT;
        end else begin
            return `COUNTS_20BIT;
        end
    endfunction : res_counts

    function automatic logic ppr_ok(input logic [31:0] p, input enc_res_t r);
        logic [31:0] top;
        logic [3:0] mask;
        top = (r == RES_13BIT) ? `PPR_MAX_13BIT : (r == RES_17BIT) ? `PPR_MAX_17BIT : `PPR_MAX_20BIT;
        if (p <= `PPR_STEP1_TOP) begin
            mask = 4'h0;
        end else if (p <= `PPR_STEP2_TOP) begin
            mask = 4'h1;
        end else if (p <= `PPR_STEP4_TOP) begin
            mask = 4'h3;
        end else if (p <= `PPR_STEP8_TOP) begin
            mask = 4'h7;
        end else begin
            mask = 4'hF;
        end
        return (p >= `PPR_MIN) && (p <= top) && ((p[3:0] & mask) == 4'h0);
    endfunction : ppr_ok

    function automatic logic [15:0] speed_limit(input logic [31:0] p);
        if (p <= `PPR_STEP1_TOP) begin
            return `SPEED_LIM_0;
        end else if (p <= `PPR_STEP2_TOP) begin
            return `SPEED_LIM_1;
        end else if (p <= `PPR_STEP4_TOP) begin
            return `SPEED_LIM_2;
        end else if (p <= `PPR_STEP8_TOP) begin
            return `SPEED_LIM_3;
        end else begin
            return `SPEED_LIM_4;
        end
    endfunction : speed_limit

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic loaded_ff, nxt_loaded;
    logic [31:0] ppr_ff, nxt_ppr;
    enc_res_t res_ff, nxt_res;
    logic run_ff, nxt_run;
    logic [22:0] acc_ff, nxt_acc;
    logic signed [4:0] pend_ff, nxt_pend;
    logic [7:0] gap_ff, nxt_gap;
    logic [1:0] q_ff, nxt_q;
    logic armed_ff, nxt_armed;
    logic c_ff, nxt_c;
    logic a_ff, nxt_a;
    logic b_ff, nxt_b;
    logic set_alm_ff, nxt_set_alm;
    logic os_alm_ff, nxt_os_alm;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [22:0] inc;
        logic [22:0] full;
        logic fwd;
        logic signed [4:0] req;
        nxt_loaded = 1'b1;
        nxt_ppr = ppr_ff;
        nxt_res = res_ff;
        nxt_run = run_ff;
        nxt_acc = acc_ff;
        nxt_pend = pend_ff;
        nxt_gap = gap_ff;
        nxt_q = q_ff;
        nxt_armed = armed_ff;
        nxt_c = c_ff;
        nxt_set_alm = set_alm_ff;
        nxt_os_alm = os_alm_ff;
        inc = {1'b0, ppr_ff[19:0], 2'b00};
        full = {2'b00, res_counts(res_ff)};
        fwd = enc_in.dir ^ rotation_direction_select;
        req = 5'sd0;
        if (!loaded_ff) begin
            // Setting captured once per restart
            nxt_ppr = pulses_per_rev_setting;
            nxt_res = enc_res;
        end else begin
            nxt_set_alm = set_alm_ff | !ppr_ok(ppr_ff, res_ff);
            nxt_run = ppr_ok(ppr_ff, res_ff);
            if (32'(motor_speed_rpm) > 32'(speed_limit(ppr_ff))) begin
                nxt_os_alm = 1'b1;
            end
        end
        if (run_ff && enc_in.step) begin
            // Fractional divider, one edge per count at most
            if (fwd) begin
                if (acc_ff + inc >= full) begin
                    nxt_acc = 23'(acc_ff + inc - full);
                    req = 5'sd1;
                end else begin
                    nxt_acc = 23'(acc_ff + inc);
                end
            end else begin
                if (acc_ff < inc) begin
                    nxt_acc = 23'(acc_ff + full - inc);
                    req = -5'sd1;
                end else begin
                    nxt_acc = 23'(acc_ff - inc);
                end
            end
        end
        nxt_pend = 5'(pend_ff + req);
        if (gap_ff != 8'h00) begin
            nxt_gap = 8'(gap_ff - 8'h01);
        end else if (nxt_pend != 5'sd0) begin
            // Edges spaced to cap the pulse rate
            nxt_gap = 8'(GAP_CYC - 1);
            if (nxt_pend > 5'sd0) begin
                nxt_q = 2'(q_ff + 2'd1);
                nxt_pend = 5'(nxt_pend - 5'sd1);
            end else begin
                nxt_q = 2'(q_ff - 2'd1);
                nxt_pend = 5'(nxt_pend + 5'sd1);
            end
        end
        // Gray sequence 00,10,11,01 on (A,B)
        nxt_a = nxt_q[1] ^ nxt_q[0];
        nxt_b = nxt_q[1];
        if (run_ff && enc_in.index) begin
            nxt_armed = 1'b1;
        end
        if (armed_ff && nxt_a && !a_ff) begin
            nxt_c = 1'b1;
            nxt_armed = run_ff && enc_in.index;
        end else if (!nxt_a && a_ff) begin
            nxt_c = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loaded_ff <= 1'b0;
            ppr_ff <= `PPR_DEFAULT;
            res_ff <= RES_20BIT;
            run_ff <= 1'b0;
            acc_ff <= 23'h00_0000;
            pend_ff <= 5'sd0;
            gap_ff <= 8'h00;
            q_ff <= 2'h0;
            armed_ff <= 1'b0;
            c_ff <= 1'b0;
            a_ff <= 1'b0;
            b_ff <= 1'b0;
            set_alm_ff <= 1'b0;
            os_alm_ff <= 1'b0;
        end else begin
            loaded_ff <= nxt_loaded;
            ppr_ff <= nxt_ppr;
            res_ff <= nxt_res;
            run_ff <= nxt_run;
            acc_ff <= nxt_acc;
            pend_ff <= nxt_pend;
            gap_ff <= nxt_gap;
            q_ff <= nxt_q;
            armed_ff <= nxt_armed;
            c_ff <= nxt_c;
            a_ff <= nxt_a;
            b_ff <= nxt_b;
            set_alm_ff <= nxt_set_alm;
            os_alm_ff <= nxt_os_alm;
        end
    end

    // ----------------------------------------
    // Output pins
    // ----------------------------------------
    logic an_ff, bn_ff, cn_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            an_ff <= 1'b1;
            bn_ff <= 1'b1;
            cn_ff <= 1'b1;
        end else begin
            an_ff <= !nxt_a;
            bn_ff <= !nxt_b;
            cn_ff <= !nxt_c;
        end
    end

    assign quad_out_a = a_ff;
    assign quad_out_a_n = an_ff;
    assign quad_out_b = b_ff;
    assign quad_out_b_n = bn_ff;
    assign origin_pulse_out = c_ff;
    assign origin_pulse_out_n = cn_ff;
    assign alarms = '{setting_alarm: set_alm_ff, overspeed_alarm: os_alm_ff};

endmodule : encoder_pulse_output_divider

// >>> bench/encoder_pulse_output_divider_properties.sv
// Checker for the encoder pulse output divider.
// Assumes it is bound to the divider top module.
`timescale 1ns/10ps
module enc_div_checker #(
    parameter int GAP_CYC = 16
) (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic quad_out_a, // Phase A
    input wire logic quad_out_a_n, // Phase A inverted
    input wire logic quad_out_b, // Phase B
    input wire logic quad_out_b_n, // Phase B inverted
    input wire logic origin_pulse_out, // Phase C
    input wire logic origin_pulse_out_n, // Phase C inverted
    input wire enc_pkg::alarm_t alarms // Alarms
);
    import enc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_quiet8;
        ($stable(quad_out_a) && $stable(quad_out_b)) [*8];
    endsequence
    sequence s_quiet7;
        ($stable(quad_out_a) && $stable(quad_out_b)) [*7];
    endsequence
    sequence s_c_then_a;
        origin_pulse_out ##1 quad_out_a;
    endsequence
    chk_a_inverse: assert property (quad_out_a_n == !quad_out_a)
        else $error("A inverse wrong");
    chk_b_inverse: assert property (quad_out_b_n == !quad_out_b)
        else $error("B inverse wrong");
    chk_c_inverse: assert property (origin_pulse_out_n == !origin_pulse_out)
        else $error("C inverse wrong");
    chk_one_phase: assert property (!($changed(quad_out_a) && $changed(quad_out_b)))
        else $error("A and B moved together");
    chk_edge_gap: assert property (GAP_CYC >= 16 && ($changed(quad_out_a) || $changed(quad_out_b))
        |=> s_quiet8 ##1 s_quiet7)
        else $error("Edges too close");
    chk_origin_rise: assert property ($rose(origin_pulse_out) |-> $rose(quad_out_a))
        else $error("C rise not on A rise");
    chk_origin_width: assert property (origin_pulse_out |-> quad_out_a)
        else $error("C high outside A high");
    chk_origin_holds: assert property (s_c_then_a |-> origin_pulse_out)
        else $error("C ended early");
    chk_alarm_frozen: assert property (alarms.setting_alarm
        |-> !quad_out_a && !quad_out_b && !origin_pulse_out)
        else $error("Pulses with bad setting");
    chk_setting_sticky: assert property (alarms.setting_alarm |=> alarms.setting_alarm)
        else $error("Setting alarm dropped");
    chk_speed_sticky: assert property (alarms.overspeed_alarm |=> alarms.overspeed_alarm)
        else $error("Overspeed alarm dropped");
endmodule : enc_div_checker

bind encoder_pulse_output_divider enc_div_checker #(.GAP_CYC(GAP_CYC)) i_chk (.clk_sys, .rst,
    .quad_out_a, .quad_out_a_n, .quad_out_b, .quad_out_b_n, .origin_pulse_out, .origin_pulse_out_n, .alarms);

// >>> bench/host_quad_counter.sv
// Host counter decoding the divided quadrature output.
// Assumes the phases are sampled on the rising system clock.
`timescale 1ns/10ps
module host_quad_counter (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic quad_a, // Phase A in
    input wire logic quad_b, // Phase B in
    input wire logic origin, // Phase C in
    output logic [31:0] pos_cnt, // Position count
    output logic [31:0] origin_cnt, // Origin pulses seen
    output logic [31:0] bad_cnt // Illegal phase jumps
);
    logic [1:0] ph_ff;
    logic c_ff;
    logic [1:0] ph;
    logic [1:0] dph;
    assign ph = {quad_b, quad_a ^ quad_b};
    assign dph = ph - ph_ff;
    // Decodes one edge per cycle, above the capped rate
    always_ff @(posedge clk_sys) begin
        ph_ff <= ph;
        c_ff <= origin;
        if (rst) begin
            pos_cnt <= '0;
            origin_cnt <= '0;
            bad_cnt <= '0;
        end else begin
            if (dph == 2'h1) pos_cnt <= pos_cnt + 32'h1;
            if (dph == 2'h3) pos_cnt <= pos_cnt - 32'h1;
            if (dph == 2'h2) bad_cnt <= bad_cnt + 32'h1;
            if (origin && !c_ff) origin_cnt <= origin_cnt + 32'h1;
        end
    end
endmodule : host_quad_counter

// >>> bench/tb_encoder_pulse_output_divider.sv
// Testbench for the encoder pulse output divider.
// Assumes the host counter model and the bound checker.
`timescale 1ns/10ps
module tb_encoder_pulse_output_divider;
    import enc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    enc_in_t enc_in = '0;
    enc_res_t enc_res = RES_20BIT;
    logic [31:0] pulses_per_rev_setting = 32'h800;
    logic rotation_direction_select = 1'b0;
    logic [15:0] motor_speed_rpm = 16'h0;
    logic quad_out_a, quad_out_a_n, quad_out_b, quad_out_b_n, origin_pulse_out, origin_pulse_out_n;
    alarm_t alarms;
    logic [31:0] pos, org, bad;
    int error_cnt = 0;
    int checked = 0;
    always #5 clk_sys = ~clk_sys;
    encoder_pulse_output_divider i_dut (.clk_sys, .rst, .enc_in, .enc_res, .pulses_per_rev_setting,
        .rotation_direction_select, .motor_speed_rpm, .quad_out_a, .quad_out_a_n, .quad_out_b,
        .quad_out_b_n, .origin_pulse_out, .origin_pulse_out_n, .alarms);
    host_quad_counter i_host (.clk_sys, .rst, .quad_a(quad_out_a), .quad_b(quad_out_b),
        .origin(origin_pulse_out), .pos_cnt(pos), .origin_cnt(org), .bad_cnt(bad));
    // ----
    // Helpers
    // ----
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task final_report;
        $display("Compares %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task restart(input enc_res_t r, input logic [31:0] p);
        @(negedge clk_sys);
        rst = 1'b1;
        enc_res = r;
        pulses_per_rev_setting = p;
        motor_speed_rpm = 16'h0;
        rotation_direction_select = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : restart
    task steps(input int n, input logic d, input logic idx);
        repeat (n) begin
            enc_in = {1'b1, d, idx};
            idx = 1'b0;
            @(negedge clk_sys);
        end
        enc_in = '0;
    endtask : steps
    task wait_pos(input logic [31:0] exp);
        int i;
        for (i = 0; i < 400 && pos !== exp; i++) @(negedge clk_sys);
        chk(pos, exp);
        if (pos !== exp) final_report;
    endtask : wait_pos
    // ----
    // Scenarios
    // ----
    task t_rev;
        restart(RES_13BIT, 32'h10);
        chk({quad_out_a, quad_out_a_n, quad_out_b, quad_out_b_n, origin_pulse_out_n}, 5'b01011);
        steps(8192, 1'b1, 1'b1);
        wait_pos(32'h40);
        chk(org, 32'h1);
        steps(8192, 1'b0, 1'b1);
        wait_pos(32'h0);
        chk(org, 32'h2);
        rotation_direction_select = 1'b1;
        steps(512, 1'b1, 1'b0);
        wait_pos(32'hFFFF_FFFC);
        chk(org, 32'h2);
        chk(bad, 32'h0);
    endtask : t_rev
    task t_gap;
        restart(RES_20BIT, 32'h4_0000);
        steps(10, 1'b1, 1'b0);
        wait_pos(32'hA);
    endtask : t_gap
    task automatic t_setting;
        enc_res_t r [9] = '{RES_13BIT, RES_13BIT, RES_17BIT, RES_17BIT, RES_20BIT, RES_20BIT,
            RES_20BIT, RES_20BIT, RES_20BIT};
        logic [31:0] p [9] = '{32'h800, 32'h801, 32'h4000, 32'h4001, 32'h61A8, 32'h61A9, 32'hF,
            32'h4_0000, 32'h4_0010};
        logic e [9] = '{0, 1, 0, 1, 0, 1, 1, 0, 1};
        for (int i = 0; i < 9; i++) begin
            restart(r[i], p[i]);
            steps(4, 1'b1, 1'b0);
            chk(alarms.setting_alarm, e[i]);
        end
        restart(RES_20BIT, 32'h4_0000);
        pulses_per_rev_setting = 32'h61A9;
        steps(3, 1'b1, 1'b0);
        wait_pos(32'h3);
        chk(alarms.setting_alarm, 1'b0);
    endtask : t_setting
    task automatic t_speed;
        logic [31:0] p [5] = '{32'h4000, 32'h8000, 32'h1_0000, 32'h2_0000, 32'h4_0000};
        logic [15:0] l [5] = '{16'h1770, 16'h0BB8, 16'h05DC, 16'h02EE, 16'h0177};
        for (int i = 0; i < 5; i++) begin
            restart(RES_20BIT, p[i]);
            motor_speed_rpm = l[i];
            repeat (3) @(negedge clk_sys);
            chk(alarms.overspeed_alarm, 1'b0);
            motor_speed_rpm = l[i] + 16'h1;
            repeat (2) @(negedge clk_sys);
            chk(alarms.overspeed_alarm, 1'b1);
        end
    endtask : t_speed
    initial begin
        t_rev;
        t_gap;
        t_setting;
        t_speed;
        final_report;
    end
endmodule : tb_encoder_pulse_output_divider
